// >>> verif/quad_split_checker_asserts.sv
// Checker of bus answers, output gating and format flag.
// Sees top ports only; clk_en stays high in this bench.
`timescale 1ns/100ps
module quad_split_checker import quad_split_pkg::*; (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire video_in_type [3:0] video_in,
	input wire logic [2:0] ref_locked,
	input wire video_out_type video_out,
	input wire logic fmt_error_led,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready
);
	// ********************
	// Properties
	// ********************
	logic all_lost;
	assign all_lost = video_in[0].lost && video_in[1].lost && video_in[2].lost && video_in[3].lost;
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	wr_answer_a: assert property (awvalid && awready && wvalid && wready |=> bvalid)
		else $error("write not answered");
	wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	wr_refuse_a: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answering");
	rd_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered");
	rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	rd_refuse_a: assert property (rvalid |-> !arready)
		else $error("read taken while answering");
	rd_error_a: assert property (rvalid && rresp == 2'b10 |-> rdata == 32'h0)
		else $error("error read not zero");
	no_ref_a: assert property ((ref_locked == 3'b000) [*8] |-> !video_out.valid)
		else $error("output without reference");
	fmt_idle_a: assert property (all_lost [*3] |-> !fmt_error_led)
		else $error("format flag with no input");
endmodule
bind quad_split_video_compositor quad_split_checker u_quad_split_checker (.*);

// >>> verif/quad_split_video_compositor_tb_top.sv
// Bench: register tasks over AXI4-Lite, then picture and status checks.
// Assumes the source model times every input to the reference.
`timescale 1ns/100ps
`include "quad_split_map.svh"
module quad_split_video_compositor_tb_top import quad_split_pkg::*;;
	localparam int LC = 80;
	localparam logic [31:0] PROC_TAB [3] = '{32'h0080_8080, 32'h1040_8080, 32'h0080_4080};
	localparam logic [31:0] CTRL_TAB [3] = '{32'h1000, 32'h1010, 32'h1010};
	localparam logic [31:0] EXP_TAB [3] = '{32'h80a0a0, 32'h9090a0, 32'h809090};
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic [3:0] lost = 4'h0;
	logic [3:0] format = 4'h0;
	pix_type pix = 24'h80a0a0;
	logic locked = 1'b1;
	video_in_type [3:0] video_in;
	logic [2:0] ref_sync;
	logic [2:0] ref_locked;
	video_out_type video_out;
	logic fmt_error_led;
	logic [11:0] awaddr = 12'h0;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [11:0] araddr = 12'h0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic [31:0] rdv;
	logic [1:0] rsp;
	int error_cnt = 0;
	int tests_run = 0;
	video_source_model #(.LINE_CLOCKS(LC), .FRAME_LINES(40), .ACTIVE_H(32)) u_video_source_model (.*);
	quad_split_video_compositor #(.ACTIVE_W(64), .ACTIVE_H(32), .LINE_CLOCKS(LC),
		.FRAME_LINES(40)) u_quad_split_video_compositor (.*);
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	// ********************
	// Tasks
	// ********************
	task automatic summarize();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic timeout();
		error_cnt++;
		$display("Error at %0t: wait ran out", $time);
		summarize();
	endtask
	task automatic wait_hi(ref logic s);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
			if (n > 5000) timeout();
		end while (s !== 1'b1);
	endtask
	task automatic wait_out(input logic act);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
			if (n > 5000) timeout();
		end while (!(video_out.valid === 1'b1 && video_out.active === act));
	endtask
	// A bubble edge after each answer keeps strobes single-assigned
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		wait_hi(awready);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		wait_hi(bvalid);
		r = bresp;
		bready <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		wait_hi(arready);
		arvalid <= 1'b0;
		wait_hi(rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		rd(a, rdv, rsp);
		check(rdv, e);
		check(rsp, `RESP_OKAY);
	endtask
	// ********************
	// Sequence
	// ********************
	initial begin
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		rchk(`OFS_CTRL, `CTRL_RESET);
		rchk(`OFS_PROC, `PROC_RESET);
		rchk(`OFS_QUAD, `QUAD_RESET);
		rchk(`OFS_BORDER, `BORDER_COLOR_RESET);
		rchk(`OFS_BORDER + 12'h4, `BORDER_CFG_RESET);
		wr(`OFS_BORDER + 12'h4, 32'h0000_0280, rsp);
		rchk(`OFS_BORDER + 12'h4, 32'h0000_0280);
		wr(`OFS_STATUS, 32'hffff_ffff, rsp);
		check(rsp, `RESP_SLVERR);
		rd(12'h300, rdv, rsp);
		check(rdv, 32'h0);
		check(rsp, `RESP_SLVERR);
		repeat (6400) @(posedge sys_clk);
		rchk(`OFS_OUT_TIMING, LC / 2);
		for (int i = 0; i < 3; i++) begin
			wr(`OFS_PROC, PROC_TAB[i], rsp);
			wr(`OFS_CTRL, CTRL_TAB[i], rsp);
			repeat (8) @(posedge sys_clk);
			wait_out(1'b1);
			check(video_out.pix, EXP_TAB[i]);
		end
		wr(`OFS_CTRL, 32'h1000, rsp);
		lost <= 4'hf;
		format <= 4'h1;
		repeat (100) @(posedge sys_clk);
		wait_out(1'b1);
		check(video_out.pix, {`BLUE_Y, `BLUE_CB, `BLUE_CR});
		check(fmt_error_led, 1'b0);
		lost <= 4'he;
		repeat (200) @(posedge sys_clk);
		check(fmt_error_led, 1'b1);
		rd(`OFS_STATUS, rdv, rsp);
		check(rdv[4:0], 5'h1d);
		locked <= 1'b0;
		repeat (12) @(posedge sys_clk);
		check(video_out.valid, 1'b0);
		locked <= 1'b1;
		lost <= 4'h0;
		format <= 4'h0;
		wr(`OFS_CTRL, 32'h1001, rsp);
		repeat (9600) @(posedge sys_clk);
		rd(`OFS_STATUS, rdv, rsp);
		check(rdv[12:9], 4'hf);
		// Input sof meets the output raster half a line before its last line ends
		rchk(`OFS_IN_TIMING, {16'd39, 16'd40});
		for (int s = 0; s < 4; s++) begin
			wr(`OFS_BORDER + 12'(8 * s), 32'h0, rsp);
			wr(`OFS_BORDER + 12'(8 * s) + 12'h4, 32'h0000_0200, rsp);
		end
		repeat (8) @(posedge sys_clk);
		wait_out(1'b1);
		check(video_out.pix, {`BLACK_Y, `CHROMA_ZERO, `CHROMA_ZERO});
		for (int s = 0; s < 4; s++) begin
			wr(`OFS_BORDER + 12'(8 * s) + 12'h4, 32'h0000_02ff, rsp);
		end
		repeat (8) @(posedge sys_clk);
		wait_out(1'b1);
		check(video_out.pix, 24'h80a0a0);
		wr(`OFS_QUAD, 32'h0, rsp);
		repeat (8) @(posedge sys_clk);
		wait_out(1'b1);
		check(video_out.pix, {`BLACK_Y, `CHROMA_ZERO, `CHROMA_ZERO});
		wait_out(1'b0);
		check(video_out.pix, {`BLACK_Y, `CHROMA_ZERO, `CHROMA_ZERO});
		summarize();
	end
endmodule

// >>> verif/video_source_model.sv
// Four sources and an analog reference on one raster.
// Assumes one sample per clock; lost sources show no sync.
`timescale 1ns/100ps
module video_source_model import quad_split_pkg::*; #(
	parameter int LINE_CLOCKS = 80,
	parameter int FRAME_LINES = 40,
	parameter int ACTIVE_H = 32
)(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [3:0] lost,
	input wire logic [3:0] format,
	input wire pix_type pix,
	input wire logic locked,
	output video_in_type [3:0] video_in,
	output logic [2:0] ref_sync,
	output logic [2:0] ref_locked
);
	logic [15:0] h;
	logic [15:0] v;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			h <= 16'h0;
			v <= 16'h0;
		end else if (h == LINE_CLOCKS - 1) begin
			h <= 16'h0;
			v <= (v == FRAME_LINES - 1) ? 16'h0 : v + 16'h1;
		end else begin
			h <= h + 16'h1;
		end
	end
	// Sources line up with the reference, well inside half a line
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			video_in[i].lost = lost[i];
			video_in[i].format = format;
			video_in[i].valid = !lost[i];
			video_in[i].sof = h == 16'h0 && v == 16'h0 && !lost[i];
			video_in[i].sol = h == 16'h0 && v < ACTIVE_H && !lost[i];
			// A dead input carries no picture, so not the last value either
			video_in[i].pix = lost[i] ? ~pix : pix;
		end
		ref_sync = {2'b00, h == 16'h0 && v == 16'h0};
		ref_locked = {2'b00, locked};
	end
endmodule

// >>> verilog/proc_amp.sv
// Per-output processing amplifier, one pipeline stage.
// Assumes gains with unity at 8'h80 and a signed black offset.
`timescale 1ns/100ps
`include "quad_split_map.svh"
module proc_amp import quad_split_pkg::*; (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic enable,
	input wire logic [7:0] video_gain,
	input wire logic [7:0] chroma_gain,
	input wire logic [7:0] blue_difference_gain,
	input wire logic signed [7:0] black_offset,
	input wire pix_type pix_in,
	output pix_type pix_out
);
	logic signed [19:0] dy, dcb, dcr, ty, tcb, tcr;
	pix_type next_pix;

	// Clip away from the reserved timing codes
	function automatic logic [7:0] clip(input logic signed [19:0] v);
		if (v < `CLIP_LO) begin
			return 8'h01;
		end
		if (v > `CLIP_HI) begin
			return 8'hfe;
		end
		return v[7:0];
	endfunction

	function automatic logic signed [19:0] scale(input logic signed [19:0] v,
		input logic [7:0] g);
		return (v * signed'(20'(g))) >>> `GAIN_SHIFT;
	endfunction

	always_comb begin
		dy = 20'(pix_in.y) - 20'(`BLACK_Y);
		dcb = 20'(pix_in.cb) - 20'(`CHROMA_ZERO);
		dcr = 20'(pix_in.cr) - 20'(`CHROMA_ZERO);
		ty = scale(dy, video_gain) + 20'(`BLACK_Y) + 20'(black_offset);
		tcb = scale(scale(scale(dcb, video_gain), chroma_gain), blue_difference_gain);
		tcr = scale(scale(dcr, video_gain), chroma_gain);
		next_pix = pix_in;
		if (enable) begin
			next_pix.y = clip(ty);
			next_pix.cb = clip(tcb + 20'(`CHROMA_ZERO));
			next_pix.cr = clip(tcr + 20'(`CHROMA_ZERO));
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pix_out <= '0;
		end else if (clk_en) begin
			pix_out <= next_pix;
		end
	end
endmodule

// >>> verilog/quad_split_map.svh
// Register map, field positions, reset values and picture codes.
// Included by the compositor and its processing amplifier.
`ifndef QUAD_SPLIT_MAP_SVH
`define QUAD_SPLIT_MAP_SVH
// ********************
// Register byte offsets
// ********************
`define OFS_CTRL 12'h000
`define OFS_PROC 12'h004
`define OFS_QUAD 12'h008
`define OFS_STATUS 12'h00c
`define OFS_OUT_TIMING 12'h010
`define OFS_IN_TIMING 12'h020
`define OFS_BORDER 12'h040
`define OFS_LABEL 12'h400
// ********************
// Reset values
// ********************
`define CTRL_RESET 32'h0000_1000
`define PROC_RESET 32'h0080_8080
`define QUAD_RESET 32'h0000_08d1
`define BORDER_COLOR_RESET 32'h00ff_ffff
`define BORDER_CFG_RESET 32'h0000_0000
// ********************
// Field positions
// ********************
`define CTRL_QUAD_BIT 0
`define CTRL_REF_LSB 1
`define CTRL_REL_BIT 3
`define CTRL_PROC_EN_BIT 4
`define CTRL_FMT_LSB 8
`define CTRL_FULL_LSB 12
`define PROC_VGAIN_LSB 0
`define PROC_CGAIN_LSB 8
`define PROC_CBGAIN_LSB 16
`define PROC_OFFSET_LSB 24
`define BORDER_TRANS_LSB 0
`define BORDER_TH_LSB 8
`define SRC_BITS 3
// ********************
// Picture codes and arithmetic
// ********************
`define BLACK_Y 8'h10
`define CHROMA_ZERO 8'h80
`define WHITE_Y 8'heb
`define BLUE_Y 8'h29
`define BLUE_CB 8'hf0
`define BLUE_CR 8'h6e
`define CLIP_LO 20'sd1
`define CLIP_HI 20'sd254
`define GAIN_SHIFT 7
`define KY_R 18'sd47
`define KY_G 18'sd157
`define KY_B 18'sd16
`define KB_R 18'sd26
`define KB_G 18'sd87
`define KC_MAX 18'sd112
`define KR_G 18'sd102
`define KR_B 18'sd10
// ********************
// Label bitmap, timing and bus responses
// ********************
`define LABEL_ROW_BITS 4
`define LABEL_COL_BITS 7
`define LABEL_WORDS 64
`define OUT_OFFSET_LINE_NUM 1
`define OUT_OFFSET_LINE_DEN 2
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// >>> verilog/quad_split_pkg.sv
// Types shared by the compositor and its processing amplifier.
// Assumes 8-bit 4:4:4 samples carried one pixel per clock.
package quad_split_pkg;
	typedef struct packed {
		logic [7:0] y;
		logic [7:0] cb;
		logic [7:0] cr;
	} pix_type;
	typedef struct packed {
		logic lost;
		logic [3:0] format;
		logic valid;
		logic sof;
		logic sol;
		pix_type pix;
	} video_in_type;
	typedef struct packed {
		logic valid;
		logic sof;
		logic sol;
		logic active;
		pix_type pix;
	} video_out_type;
	typedef struct packed {
		logic valid;
		logic sof;
		logic sol;
		logic active;
		logic [1:0] q;
		logic [15:0] lx;
		logic [15:0] ly;
	} stage_type;
endpackage

// >>> verilog/quad_split_video_compositor.sv
// Quad split compositor for one output: four inputs, line and frame stores,
// borders, labels, processing amplifier, reference lock and timing status.
// Assumes inputs are synchronous to sys_clk, sol marks the first active sample
// and every line sample (active then blanking) arrives with valid set.
`timescale 1ns/100ps
`include "quad_split_map.svh"
module quad_split_video_compositor import quad_split_pkg::*; #(
	parameter int ACTIVE_W = 1920,
	parameter int ACTIVE_H = 1080,
	parameter int LINE_CLOCKS = 4400,
	parameter int FRAME_LINES = 1125
)(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire video_in_type [3:0] video_in,
	input wire logic [2:0] ref_sync,
	input wire logic [2:0] ref_locked,
	output video_out_type video_out,
	output logic fmt_error_led,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	localparam int QW = ACTIVE_W / 2;
	localparam int QH = ACTIVE_H / 2;
	localparam int QDEPTH = QW * QH;
	localparam int QAW = $clog2(QDEPTH);
	localparam int LAW = $clog2(LINE_CLOCKS);
	localparam int LW = 1 << `LABEL_COL_BITS;
	localparam int LH = 1 << `LABEL_ROW_BITS;
	localparam int LX0 = (QW - LW) / 2;
	localparam int OFFSET_CLOCKS = LINE_CLOCKS * `OUT_OFFSET_LINE_NUM / `OUT_OFFSET_LINE_DEN;
	localparam pix_type BLACK = '{`BLACK_Y, `CHROMA_ZERO, `CHROMA_ZERO};
	localparam pix_type BLUE = '{`BLUE_Y, `BLUE_CB, `BLUE_CR};
	localparam pix_type WHITE = '{`WHITE_Y, `CHROMA_ZERO, `CHROMA_ZERO};

	// ********************
	// Registers and fields
	// ********************
	logic [31:0] ctrl, proc, quad;
	logic [31:0] border_color [4];
	logic [31:0] border_cfg [4];
	logic [31:0] label_mem [4][`LABEL_WORDS];
	logic [31:0] out_timing;
	logic [31:0] in_timing [4];
	logic [3:0] frame_done, aligned, fmt_mismatch;
	logic quad_mode, timing_rel, proc_enable;
	logic [1:0] ref_sel;
	logic [3:0] out_format;
	logic [2:0] full_src;
	logic wr_fire, rd_fire, wr_ok, rd_ok;
	logic [31:0] rd_word;

	assign quad_mode = ctrl[`CTRL_QUAD_BIT];
	assign ref_sel = ctrl[`CTRL_REF_LSB +: 2];
	assign timing_rel = ctrl[`CTRL_REL_BIT];
	assign proc_enable = ctrl[`CTRL_PROC_EN_BIT];
	assign out_format = ctrl[`CTRL_FMT_LSB +: 4];
	assign full_src = ctrl[`CTRL_FULL_LSB +: `SRC_BITS];

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		return (a <= `OFS_OUT_TIMING && a[1:0] == 2'b00) || (a[11:4] == `OFS_IN_TIMING >> 4)
			|| (a[11:5] == `OFS_BORDER >> 5) || (a[11:10] == `OFS_LABEL >> 10);
	endfunction

	// ********************
	// Register bus slave
	// ********************
	// Address and data are taken together; saves a holding register
	assign wr_fire = awvalid && wvalid && !bvalid;
	assign awready = wr_fire;
	assign wready = wr_fire;
	assign arready = !rvalid;
	assign rd_fire = arvalid && !rvalid;
	assign wr_ok = mapped(awaddr) && awaddr[11:10] != 2'b00 || mapped(awaddr)
		&& awaddr != `OFS_STATUS && awaddr != `OFS_OUT_TIMING && awaddr[11:4] != 8'h02;
	assign rd_ok = mapped(araddr);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= `CTRL_RESET;
			proc <= `PROC_RESET;
			quad <= `QUAD_RESET;
			for (int s = 0; s < 4; s++) begin
				border_color[s] <= `BORDER_COLOR_RESET;
				border_cfg[s] <= `BORDER_CFG_RESET;
			end
		end else if (clk_en && wr_fire) begin
			if (awaddr == `OFS_CTRL) begin
				ctrl <= merge(ctrl, wdata, wstrb);
			end
			if (awaddr == `OFS_PROC) begin
				proc <= merge(proc, wdata, wstrb);
			end
			if (awaddr == `OFS_QUAD) begin
				quad <= merge(quad, wdata, wstrb);
			end
			if (awaddr[11:5] == `OFS_BORDER >> 5 && !awaddr[2]) begin
				border_color[awaddr[4:3]] <= merge(border_color[awaddr[4:3]], wdata, wstrb);
			end
			if (awaddr[11:5] == `OFS_BORDER >> 5 && awaddr[2]) begin
				border_cfg[awaddr[4:3]] <= merge(border_cfg[awaddr[4:3]], wdata, wstrb);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (clk_en && wr_fire && awaddr[11:10] == `OFS_LABEL >> 10) begin
			label_mem[awaddr[9:8]][awaddr[7:2]] <=
				merge(label_mem[awaddr[9:8]][awaddr[7:2]], wdata, wstrb);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
		end else if (clk_en) begin
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_word = 32'h0;
		case (araddr[11:10])
			2'b00: begin
				if (araddr == `OFS_CTRL) rd_word = ctrl;
				if (araddr == `OFS_PROC) rd_word = proc;
				if (araddr == `OFS_QUAD) rd_word = quad;
				if (araddr == `OFS_STATUS) rd_word = {19'h0, aligned, fmt_mismatch,
					video_in[3].lost, video_in[2].lost, video_in[1].lost, video_in[0].lost,
					ref_sel != 2'd3 && ref_locked[ref_sel]};
				if (araddr == `OFS_OUT_TIMING) rd_word = out_timing;
				if (araddr[11:4] == `OFS_IN_TIMING >> 4) rd_word = in_timing[araddr[3:2]];
				if (araddr[11:5] == `OFS_BORDER >> 5) begin
					rd_word = araddr[2] ? border_cfg[araddr[4:3]] : border_color[araddr[4:3]];
				end
			end
			2'b01: rd_word = label_mem[araddr[9:8]][araddr[7:2]];
			default: rd_word = 32'h0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= `RESP_OKAY;
		end else if (clk_en) begin
			if (rd_fire) begin
				rvalid <= 1'b1;
				rdata <= rd_ok ? rd_word : 32'h0;
				rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ********************
	// Reference and output raster
	// ********************
	logic ref_ok, ref_pulse, out_sof;
	logic [15:0] ref_h, ref_v, h, v;

	assign ref_ok = ref_sel != 2'd3 && ref_locked[ref_sel];
	assign ref_pulse = ref_sel != 2'd3 && ref_sync[ref_sel];
	assign out_sof = h == 16'h0 && v == 16'h0;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ref_h <= 16'h0;
			ref_v <= 16'h0;
		end else if (clk_en) begin
			if (ref_pulse) begin
				ref_h <= 16'h1;
				ref_v <= 16'h0;
			end else if (ref_h == 16'(LINE_CLOCKS - 1)) begin
				ref_h <= 16'h0;
				ref_v <= ref_v + 16'h1;
			end else begin
				ref_h <= ref_h + 16'h1;
			end
		end
	end

	// Reloading on every reference frame pulse keeps the half-line phase fixed
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			h <= 16'h0;
			v <= 16'h0;
		end else if (clk_en) begin
			if (ref_pulse) begin
				h <= 16'(LINE_CLOCKS - OFFSET_CLOCKS + 1);
				v <= 16'(FRAME_LINES - 1);
			end else if (h == 16'(LINE_CLOCKS - 1)) begin
				h <= 16'h0;
				v <= (v == 16'(FRAME_LINES - 1)) ? 16'h0 : v + 16'h1;
			end else begin
				h <= h + 16'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_timing <= 32'h0;
		end else if (clk_en && out_sof) begin
			out_timing <= {ref_v, ref_h};
		end
	end

	// ********************
	// Input positions, stores and status
	// ********************
	logic [15:0] in_x [4];
	logic [15:0] in_y [4];
	logic [15:0] cur_x [4];
	logic [15:0] cur_y [4];
	pix_type line_rd [4];
	pix_type quad_rd [4];
	stage_type s0, s1, s2, s3;

	function automatic logic [QAW-1:0] qaddr(input logic [15:0] y, input logic [15:0] x);
		logic [31:0] a;
		a = 32'(y) * 32'(QW) + 32'(x);
		return a[QAW-1:0];
	endfunction

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			cur_x[i] = (video_in[i].sof || video_in[i].sol) ? 16'h0 : in_x[i];
			cur_y[i] = video_in[i].sof ? 16'h0 : (video_in[i].sol ? in_y[i] + 16'h1 : in_y[i]);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 4; i++) begin
				in_x[i] <= 16'h0;
				in_y[i] <= 16'h0;
				in_timing[i] <= 32'h0;
			end
		end else if (clk_en) begin
			for (int i = 0; i < 4; i++) begin
				if (video_in[i].valid) begin
					in_x[i] <= cur_x[i] + 16'h1;
					in_y[i] <= cur_y[i];
				end
				if (video_in[i].valid && video_in[i].sof) begin
					in_timing[i] <= timing_rel ? {ref_v, ref_h} : {v, h};
				end
			end
		end
	end

	// In quad mode a frame is shown only from the output frame after it started
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_done <= 4'h0;
			aligned <= 4'h0;
			fmt_mismatch <= 4'h0;
			fmt_error_led <= 1'b0;
		end else if (clk_en) begin
			for (int i = 0; i < 4; i++) begin
				if (video_in[i].lost) begin
					frame_done[i] <= 1'b0;
					aligned[i] <= 1'b0;
				end else begin
					if (video_in[i].valid && video_in[i].sof) frame_done[i] <= 1'b1;
					if (out_sof && frame_done[i]) aligned[i] <= 1'b1;
				end
				fmt_mismatch[i] <= !video_in[i].lost && video_in[i].format != out_format;
			end
			fmt_error_led <= |fmt_mismatch;
		end
	end

	// Line store covers a whole line with blanking, one per input
	for (genvar i = 0; i < 4; i++) begin : g_in
		video_store #(.WIDTH($bits(pix_type)), .DEPTH(LINE_CLOCKS), .ADDR_W(LAW)) u_line (
			.sys_clk(sys_clk),
			.clk_en(clk_en),
			.wr_en(video_in[i].valid),
			.wr_addr(cur_x[i][LAW-1:0]),
			.wr_data(video_in[i].pix),
			.rd_addr(h[LAW-1:0]),
			.rd_data(line_rd[i])
		);
		// Decimating by two each way on entry quarters the store; no filtering, so fine detail aliases
		video_store #(.WIDTH($bits(pix_type)), .DEPTH(QDEPTH), .ADDR_W(QAW)) u_frame (
			.sys_clk(sys_clk),
			.clk_en(clk_en),
			.wr_en(video_in[i].valid && cur_x[i] < 16'(ACTIVE_W) && cur_y[i] < 16'(ACTIVE_H)
				&& !cur_x[i][0] && !cur_y[i][0]),
			.wr_addr(qaddr(cur_y[i] >> 1, cur_x[i] >> 1)),
			.wr_data(video_in[i].pix),
			.rd_addr(qaddr(s0.ly, s0.lx)),
			.rd_data(quad_rd[i])
		);
	end

	// ********************
	// Composition pipeline
	// ********************
	logic [2:0] qsrc;
	logic [1:0] si;
	logic [7:0] th, tr;
	logic in_border, in_label;
	logic [15:0] lrow, lcol;
	logic [10:0] lidx;
	pix_type cpix, comp_pix, bcol, pa_pix;

	function automatic pix_type rgb2ycc(input logic [23:0] c);
		logic signed [17:0] r, g, b, ty, tb, tc;
		r = 18'(c[23:16]);
		g = 18'(c[15:8]);
		b = 18'(c[7:0]);
		ty = ((`KY_R * r + `KY_G * g + `KY_B * b) >>> 8) + 18'(`BLACK_Y);
		tb = ((`KC_MAX * b - `KB_R * r - `KB_G * g) >>> 8) + 18'(`CHROMA_ZERO);
		tc = ((`KC_MAX * r - `KR_G * g - `KR_B * b) >>> 8) + 18'(`CHROMA_ZERO);
		return '{ty[7:0], tb[7:0], tc[7:0]};
	endfunction

	// Weight 256 at code 255 makes the top setting fully transparent
	function automatic logic [7:0] blend(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] t);
		logic [8:0] w;
		logic [16:0] s;
		w = {1'b0, t} + 9'(t[7]);
		s = 17'(a) * 17'(w) + 17'(b) * 17'(9'h100 - w);
		return s[15:8];
	endfunction

	always_comb begin
		s0.valid = ref_ok;
		s0.sof = out_sof;
		s0.sol = h == 16'h0;
		s0.active = h < 16'(ACTIVE_W) && v < 16'(ACTIVE_H);
		s0.q = {v >= 16'(QH), h >= 16'(QW)};
		s0.lx = s0.q[0] ? h - 16'(QW) : h;
		s0.ly = s0.q[1] ? v - 16'(QH) : v;
	end

	always_comb begin
		qsrc = quad[3 * s1.q +: `SRC_BITS];
		si = 2'(qsrc - 3'd1);
		th = border_cfg[si][`BORDER_TH_LSB +: 8];
		tr = border_cfg[si][`BORDER_TRANS_LSB +: 8];
		bcol = rgb2ycc(border_color[si][23:0]);
		in_border = th != 8'h0 && (s1.lx < 16'(th) || s1.ly < 16'(th)
			|| s1.lx >= 16'(QW) - 16'(th) || s1.ly >= 16'(QH) - 16'(th));
		lrow = s1.ly - 16'(QH - LH);
		lcol = s1.lx - 16'(LX0);
		lidx = {lrow[`LABEL_ROW_BITS-1:0], lcol[`LABEL_COL_BITS-1:0]};
		in_label = s1.ly >= 16'(QH - LH) && s1.lx >= 16'(LX0) && s1.lx < 16'(LX0 + LW)
			&& label_mem[si][lidx[10:5]][lidx[4:0]];
		cpix = BLACK;
		if (!s1.valid || (quad_mode && !s1.active)) begin
			cpix = BLACK;
		end else if (!quad_mode) begin
			if (full_src == 3'd0 || full_src > 3'd4) begin
				cpix = BLACK;
			end else if (video_in[2'(full_src - 3'd1)].lost) begin
				cpix = BLUE;
			end else begin
				cpix = line_rd[2'(full_src - 3'd1)];
			end
		end else if (qsrc != 3'd0 && qsrc <= 3'd4) begin
			if (video_in[si].lost) begin
				cpix = BLUE;
			end else if (aligned[si]) begin
				cpix = quad_rd[si];
			end
			if (in_border) begin
				cpix = '{blend(cpix.y, bcol.y, tr), blend(cpix.cb, bcol.cb, tr),
					blend(cpix.cr, bcol.cr, tr)};
			end
			if (in_label) begin
				cpix = WHITE;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			comp_pix <= BLACK;
		end else if (clk_en) begin
			s1 <= s0;
			s2 <= s1;
			s3 <= s2;
			comp_pix <= cpix;
		end
	end

	// Blanking bypasses the amplifier so quad-mode blanking stays legal black
	proc_amp u_proc_amp (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.enable(proc_enable && s2.valid && s2.active),
		.video_gain(proc[`PROC_VGAIN_LSB +: 8]),
		.chroma_gain(proc[`PROC_CGAIN_LSB +: 8]),
		.blue_difference_gain(proc[`PROC_CBGAIN_LSB +: 8]),
		.black_offset(signed'(proc[`PROC_OFFSET_LSB +: 8])),
		.pix_in(comp_pix),
		.pix_out(pa_pix)
	);

	assign video_out = '{s3.valid, s3.sof, s3.sol, s3.active, pa_pix};
endmodule

// >>> verilog/video_store.sv
// Simple dual-port sample store with registered read.
// Assumes one writer and one reader on the system clock.
`timescale 1ns/100ps
module video_store #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 4400,
	parameter int ADDR_W = 13
)(
	input wire logic sys_clk,
	input wire logic clk_en,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge sys_clk) begin
		if (clk_en && wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// No reset: contents are picture data, readout is gated upstream
	always_ff @(posedge sys_clk) begin
		if (clk_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule
